// ---- core/swc_cfg.svh ----
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// ************************************************************
// Timing
// ************************************************************
`define SWC_CLK_HZ          10000000
`define SWC_HOLD_OFF_S      3
`define SWC_HOLD_OFF_CYC    (`SWC_HOLD_OFF_S * `SWC_CLK_HZ)

// ************************************************************
// Wake source bit positions
// ************************************************************
`define SWC_SRC_LAN         0
`define SWC_SRC_RING        1
`define SWC_SRC_USB         2
`define SWC_SRC_PS2         3
`define SWC_SRC_PME         4
`define SWC_SRC_PCIE        5
`define SWC_SRC_BTN         6
`define SWC_NUM_SRC         7

// ************************************************************
// Reset values
// ************************************************************
`define SWC_RST_S5_LAN_EN   1'b0
`define SWC_RST_S5_PME_EN   1'b0

`endif

// ---- core/swc_pkg.sv ----
package swc_pkg;

    // Sleeping state requested by the operating system
    typedef enum logic [2:0] {
        SWC_REQ_S1 = 3'h1,
        SWC_REQ_S3 = 3'h3,
        SWC_REQ_S4 = 3'h4,
        SWC_REQ_S5 = 3'h5
    } swc_sleep_t;

    typedef enum logic [5:0] {
        SWC_ST_S0 = 6'h01,
        SWC_ST_S1 = 6'h02,
        SWC_ST_S3 = 6'h04,
        SWC_ST_S4 = 6'h08,
        SWC_ST_S5 = 6'h10,
        SWC_ST_WK = 6'h20
    } swc_state_t;

    // Raw wake sources, all from outside the clock domain
    typedef struct packed {
        logic lan_wake;
        logic modem_ring;
        logic usb_activity;
        logic ps2_activity;
        logic pme_active;
        logic pcie_wake;
    } swc_wake_src_t;

    typedef struct packed {
        logic modem_irq_unmasked;
        logic pme_wake_en;
        logic s5_lan_on;
        logic s5_pme_on;
        logic usb_dev_wake_cap;
        logic led_dual_colour;
    } swc_cfg_t;

    typedef struct packed {
        logic power_led_green;
        logic power_led_amber;
        logic cpu_hot_led;
        logic regulator_hot_led;
        logic standby_led;
    } swc_leds_t;

endpackage

// ---- core/swc_sleep_wake.sv ----
// Functional notes
// - A detected network wake-up frame from the LAN subsystem raises a wake request.
// - Modem ring resumes only from S1 or S3, external and internal modems alike.
// - Ring resume needs the modem interrupt to be unmasked.
// - USB activity wakes from S1 or S3 when the peripheral supports USB wake.
// - PS/2 keyboard or mouse activity wakes from S1 or S3.
// - PCI PME wakes from S1, S3, S4 or S5 only with wake-on-PME enabled.
// - PCI Express wake wakes from S1, S3, S4 or S5 with no enable needed.
// - Wake from S3 returns to the last working state held before sleep.
// - In S3 the supply is off and the power LED is amber if dual coloured, else dark.
// - Holding the onboard power button three seconds forces power-off; shorter does not.
// - The processor temperature LED lights while the processor runs hot.
// - The regulator temperature LED lights while the regulator runs hot.
// - The standby LED stays lit while standby power is present.
// - Wake from S5 by LAN or PME is off after defaults until set to power on.
// - Fans run in S0 and S1 and are off when off or in S3, S4 or S5.
`timescale 1ns/1ps
`include "swc_cfg.svh"

module swc_sleep_wake #(
    parameter int unsigned HOLD_OFF_CYC = `SWC_HOLD_OFF_CYC
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire swc_pkg::swc_wake_src_t wake_src,
    input  wire logic                   power_btn_pressed,
    input  wire logic                   cpu_hot,
    input  wire logic                   regulator_hot,
    input  wire logic                   sleep_req,
    input  wire swc_pkg::swc_sleep_t    sleep_state,
    input  wire swc_pkg::swc_cfg_t      cfg,
    output logic                        supply_on,
    output logic                        fan_on,
    output logic                        wake_pulse,
    output logic                        resume_from_ram,
    output logic                        forced_off,
    output swc_pkg::swc_leds_t          leds,
    output logic [`SWC_NUM_SRC-1:0]     wake_cause
);
    import swc_pkg::*;

    localparam int CW = $clog2(HOLD_OFF_CYC + 1);

    // Refuse a hold time the counter cannot time
    if (HOLD_OFF_CYC < 2) begin : g_bad_hold
        $error("HOLD_OFF_CYC must be at least 2");
    end

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int NIN = 9;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sy1_ff;
    logic [NIN-1:0] sy2_ff;
    logic [NIN-1:0] sy3_ff;
    logic [NIN-1:0] clean_ff;

    assign raw_in = {regulator_hot, cpu_hot, power_btn_pressed, wake_src};

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sy1_ff[gi]   <= 1'b0;
                    sy2_ff[gi]   <= 1'b0;
                    sy3_ff[gi]   <= 1'b0;
                    clean_ff[gi] <= 1'b0;
                end else if (clk_en) begin
                    sy1_ff[gi] <= raw_in[gi];
                    sy2_ff[gi] <= sy1_ff[gi];
                    sy3_ff[gi] <= sy2_ff[gi];
                    if (sy2_ff[gi] == sy3_ff[gi]) begin
                        clean_ff[gi] <= sy3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    swc_wake_src_t src;
    logic          btn;
    logic          cpu_hot_s;
    logic          reg_hot_s;
    assign src       = swc_wake_src_t'(clean_ff[5:0]);
    assign btn       = clean_ff[6];
    assign cpu_hot_s = clean_ff[7];
    assign reg_hot_s = clean_ff[8];

    // ************************************************************
    // Power state machine
    // ************************************************************
    swc_state_t state_ff;
    swc_state_t nxt_state;
    logic [CW-1:0] hold_cnt_ff;
    logic          btn_prev_ff;
    logic          hold_done;
    logic          btn_rise;
    logic [`SWC_NUM_SRC-1:0] wake_vec;
    logic          any_wake;

    function automatic logic in_s1_s3(input swc_state_t st);
        return (st == SWC_ST_S1) || (st == SWC_ST_S3);
    endfunction

    function automatic logic in_sleep(input swc_state_t st);
        return in_s1_s3(st) || (st == SWC_ST_S4) || (st == SWC_ST_S5);
    endfunction

    assign hold_done = btn && (hold_cnt_ff == CW'(HOLD_OFF_CYC - 1));
    assign btn_rise  = btn && !btn_prev_ff;

    always_comb begin
        wake_vec = '0;
        if (in_sleep(state_ff)) begin
            wake_vec[`SWC_SRC_LAN]  = src.lan_wake
                && ((state_ff != SWC_ST_S5) || cfg.s5_lan_on);
            wake_vec[`SWC_SRC_RING] = src.modem_ring && cfg.modem_irq_unmasked
                && in_s1_s3(state_ff);
            wake_vec[`SWC_SRC_USB]  = src.usb_activity && cfg.usb_dev_wake_cap
                && in_s1_s3(state_ff);
            wake_vec[`SWC_SRC_PS2]  = src.ps2_activity && in_s1_s3(state_ff);
            wake_vec[`SWC_SRC_PME]  = src.pme_active && cfg.pme_wake_en
                && ((state_ff != SWC_ST_S5) || cfg.s5_pme_on);
            wake_vec[`SWC_SRC_PCIE] = src.pcie_wake;
            wake_vec[`SWC_SRC_BTN]  = btn_rise;
        end
    end
    assign any_wake = |wake_vec;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SWC_ST_S0: begin
                if (sleep_req) begin
                    case (sleep_state)
                        SWC_REQ_S1: nxt_state = SWC_ST_S1;
                        SWC_REQ_S3: nxt_state = SWC_ST_S3;
                        SWC_REQ_S4: nxt_state = SWC_ST_S4;
                        SWC_REQ_S5: nxt_state = SWC_ST_S5;
                        default:    nxt_state = SWC_ST_S0;
                    endcase
                end
            end
            SWC_ST_S1, SWC_ST_S3, SWC_ST_S4, SWC_ST_S5: begin
                if (any_wake) begin
                    nxt_state = SWC_ST_WK;
                end
            end
            SWC_ST_WK: nxt_state = SWC_ST_S0;
            default:   nxt_state = SWC_ST_S5;
        endcase
        if (hold_done) begin
            nxt_state = SWC_ST_S5;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SWC_ST_S5;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Power button hold timer
    // ************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_ff <= '0;
            btn_prev_ff <= 1'b0;
        end else if (clk_en) begin
            btn_prev_ff <= btn;
            if (!btn) begin
                hold_cnt_ff <= '0;
            end else if (hold_cnt_ff != CW'(HOLD_OFF_CYC - 1)) begin
                hold_cnt_ff <= hold_cnt_ff + CW'(1);
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wake_pulse      <= 1'b0;
            resume_from_ram <= 1'b0;
            forced_off      <= 1'b0;
            wake_cause      <= '0;
        end else if (clk_en) begin
            wake_pulse      <= in_sleep(state_ff) && any_wake && !hold_done;
            resume_from_ram <= (state_ff == SWC_ST_S3) && any_wake && !hold_done;
            forced_off      <= hold_done && (state_ff != SWC_ST_S5);
            if (in_sleep(state_ff) && any_wake) begin
                wake_cause <= wake_vec;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            supply_on <= 1'b0;
            fan_on    <= 1'b0;
            leds      <= '0;
        end else if (clk_en) begin
            supply_on <= (nxt_state == SWC_ST_S0) || (nxt_state == SWC_ST_S1)
                || (nxt_state == SWC_ST_WK);
            fan_on    <= (nxt_state == SWC_ST_S0) || (nxt_state == SWC_ST_S1);
            leds.power_led_green   <= (nxt_state != SWC_ST_S3) && (nxt_state != SWC_ST_S4)
                && (nxt_state != SWC_ST_S5);
            leds.power_led_amber   <= (nxt_state == SWC_ST_S3) && cfg.led_dual_colour;
            leds.cpu_hot_led       <= cpu_hot_s;
            leds.regulator_hot_led <= reg_hot_s;
            leds.standby_led       <= 1'b1;
        end
    end

endmodule

// ---- bench/swc_partner.sv ----
`timescale 1ns/1ps
module swc_partner (
    input  wire logic              clock,
    input  wire logic [5:0]        req,
    input  wire logic              slow,
    output swc_pkg::swc_wake_src_t wake_src
);
    import swc_pkg::*;
    logic [17:0] dly_ff;
    // Slow peripherals raise their line three cycles late
    always_ff @(posedge clock) dly_ff <= {dly_ff[11:0], req};
    assign wake_src = swc_wake_src_t'(slow ? dly_ff[17:12] : req);
endmodule

// ---- bench/swc_monitor.sv ----
`timescale 1ns/1ps
module swc_monitor #(
    parameter int unsigned HOLD_OFF_CYC = 20
) (
    input wire logic               clock,
    input wire logic               rst_n,
    input wire logic               clk_en,
    input wire logic               power_btn_pressed,
    input wire logic               cpu_hot,
    input wire logic               regulator_hot,
    input wire swc_pkg::swc_cfg_t  cfg,
    input wire logic               supply_on,
    input wire logic               fan_on,
    input wire logic               wake_pulse,
    input wire logic               resume_from_ram,
    input wire logic               forced_off,
    input wire swc_pkg::swc_leds_t leds
);
    import swc_pkg::*;
    int unsigned hold_ff;
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n) hold_ff <= 0;
        else hold_ff <= power_btn_pressed ? hold_ff + 1 : 0;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wake_back_a: assert property (wake_pulse |=> fan_on && !wake_pulse)
        else $error("no return to work");
    fan_state_a: assert property (fan_on |-> supply_on && leds.power_led_green)
        else $error("fan on outside work");
    amber_s3_a: assert property (
        leds.power_led_amber |-> cfg.led_dual_colour && !supply_on)
        else $error("amber wrong");
    standby_lit_a: assert property ($past(rst_n && clk_en) |-> leds.standby_led)
        else $error("standby led dark");
    cpu_led_a: assert property (
        ($stable(cpu_hot) && clk_en) [*8] |-> leds.cpu_hot_led == cpu_hot)
        else $error("cpu led wrong");
    reg_led_a: assert property (
        ($stable(regulator_hot) && clk_en) [*8] |-> leds.regulator_hot_led == regulator_hot)
        else $error("regulator led wrong");
    resume_s3_a: assert property (resume_from_ram |-> wake_pulse && !$past(supply_on))
        else $error("resume wrong");
    forced_off_a: assert property (forced_off |-> hold_ff >= HOLD_OFF_CYC && !supply_on)
        else $error("early power off");
    cover property (resume_from_ram);
    cover property (forced_off);
    cover property (wake_pulse && !resume_from_ram);
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import swc_pkg::*;
    logic          clock = 0, rst_n = 0, btn = 0, cpu_hot = 0, reg_hot = 0, sleep_req = 0;
    logic          slow = 0, w, r, supply_on, fan_on, wake_pulse, resume_from_ram, forced_off;
    logic          ce = 1'b1;
    logic [5:0]    req = '0;
    logic [6:0]    wake_cause, c;
    swc_sleep_t    st = SWC_REQ_S1;
    swc_cfg_t      cfg = '0;
    swc_wake_src_t wake_src;
    swc_leds_t     leds;
    int            n_errors = 0, n_compared = 0, k;
    always #50 clock = ~clock;
    swc_sleep_wake #(.HOLD_OFF_CYC(20)) u_swc_sleep_wake (.clock(clock), .rst_n(rst_n),
        .clk_en(ce), .wake_src(wake_src), .power_btn_pressed(btn), .cpu_hot(cpu_hot),
        .regulator_hot(reg_hot), .sleep_req(sleep_req), .sleep_state(st), .cfg(cfg),
        .supply_on(supply_on), .fan_on(fan_on), .wake_pulse(wake_pulse),
        .resume_from_ram(resume_from_ram), .forced_off(forced_off), .leds(leds),
        .wake_cause(wake_cause));
    swc_partner u_swc_partner (.clock(clock), .req(req), .slow(slow), .wake_src(wake_src));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge clock);
        req <= v;
        {w, r, c} = 9'h000;
        repeat (12) begin
            @(posedge clock);
            #1;
            if (wake_pulse === 1'b1) {w, r, c} = {1'b1, resume_from_ram, wake_cause};
        end
        req <= '0;
        repeat (10) @(posedge clock);
    endtask
    function automatic logic exp_wake(int n, swc_sleep_t t, swc_cfg_t c);
        logic lo = t inside {SWC_REQ_S1, SWC_REQ_S3};
        logic nf = t != SWC_REQ_S5;
        logic [5:0] ok = {nf | c.s5_lan_on, lo & c.modem_irq_unmasked, lo & c.usb_dev_wake_cap,
                          lo, c.pme_wake_en & (nf | c.s5_pme_on), 1'b1};
        return ok[n];
    endfunction
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h8B7272DD));
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk(leds.standby_led, 1'b1);
        for (int i = 0; i < 48; i++) begin
            pulse(6'h01);
            cfg <= swc_cfg_t'(6'($urandom));
            slow <= 1'($urandom);
            st <= swc_sleep_t'(3'(i % 4 ? i % 4 + 2 : 1));
            sleep_req <= 1'b1;
            @(posedge clock);
            sleep_req <= 1'b0;
            #1 chk(fan_on, st == SWC_REQ_S1);
            chk(leds.power_led_amber, st == SWC_REQ_S3 && cfg.led_dual_colour);
            k = (i / 4) % 6;
            pulse(6'h01 << k);
            chk(w, exp_wake(k, st, cfg));
            if (w) chk(r, st == SWC_REQ_S3);
            if (w) chk(c, 8'(7'h01 << (5 - k)));
        end
        $display("wake done");
        pulse(6'h01);
        pulse(6'h3F);
        chk(w, 1'b0);
        st <= swc_sleep_t'(3'h2);
        sleep_req <= 1'b1;
        @(posedge clock);
        sleep_req <= 1'b0;
        #1 chk(fan_on, 1'b1);
        btn <= 1'b1;
        repeat (16) @(posedge clock);
        btn <= 1'b0;
        repeat (10) @(posedge clock);
        #1 chk(supply_on, 1'b1);
        btn <= 1'b1;
        repeat (30) @(posedge clock);
        #1 chk({supply_on, fan_on}, 2'b00);
        btn <= 1'b0;
        $display("button done");
        repeat (4) begin
            @(posedge clock);
            {cpu_hot, reg_hot} <= 2'($urandom);
            repeat (9) @(posedge clock);
            #1 chk(leds.cpu_hot_led, cpu_hot);
            chk(leds.regulator_hot_led, reg_hot);
        end
        ce <= 1'b0;
        cpu_hot <= !cpu_hot;
        repeat (10) @(posedge clock);
        #1 chk(leds.cpu_hot_led, !cpu_hot);
        ce <= 1'b1;
        repeat (9) @(posedge clock);
        #1 chk(leds.cpu_hot_led, cpu_hot);
        $display("leds done");
        summarize();
    end
    initial begin
        #1000000;
        n_errors++;
        summarize();
    end
endmodule
bind swc_sleep_wake swc_monitor #(.HOLD_OFF_CYC(HOLD_OFF_CYC)) u_swc_monitor (.clock(clock),
    .rst_n(rst_n), .clk_en(clk_en), .power_btn_pressed(power_btn_pressed), .cpu_hot(cpu_hot),
    .regulator_hot(regulator_hot), .cfg(cfg), .supply_on(supply_on), .fan_on(fan_on),
    .wake_pulse(wake_pulse), .resume_from_ram(resume_from_ram), .forced_off(forced_off),
    .leds(leds));
